/* logic/ufp_pkg.sv */
// Constants, types and decode helpers for the octal UART FIFO port and baud generator
package ufp_pkg;

    localparam int NCH        = 8;
    localparam int FIFO_DEPTH = 64;
    localparam int BYTE_W     = 8;
    localparam int RXF_W      = 16;
    localparam int LEVEL_W    = 7;

    // Byte offsets inside one 0x200 channel block
    localparam logic [8:0] OFS_HOLD   = 9'h000;
    localparam logic [8:0] OFS_MODEM  = 9'h004;
    localparam logic [8:0] OFS_LEVEL  = 9'h00c;
    localparam logic [8:0] OFS_DIV    = 9'h010;
    localparam logic [8:0] OFS_MODE   = 9'h088;
    localparam logic [8:0] OFS_BURST  = 9'h100;
    localparam logic [8:0] OFS_BURSTE = 9'h13f;
    localparam logic [8:0] OFS_STAT   = 9'h180;

    localparam int          PRESCALE_BIT  = 7;
    localparam logic [1:0]  PRESCALE_LAST = 2'h3;
    localparam logic [3:0]  BIT_LAST_16X  = 4'hf;
    localparam logic [3:0]  BIT_LAST_8X   = 4'h7;

    localparam logic [7:0]  MODEM_RESET = 8'h00;
    localparam logic [7:0]  DIV_RESET   = 8'h00;
    localparam logic [7:0]  MODE_RESET  = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_READ  = 4'h2,
        ST_WRITE = 4'h4,
        ST_DONE  = 4'h8
    } ufp_state_e;

    typedef enum logic [1:0] {
        WIN_HOLD  = 2'h0,
        WIN_BURST = 2'h1,
        WIN_STAT  = 2'h2,
        WIN_REG   = 2'h3
    } ufp_win_e;

    function automatic ufp_win_e ufp_window(input logic [8:0] sub);
        if (sub >= OFS_STAT)
            return WIN_STAT;
        else if (sub >= OFS_BURST && sub <= OFS_BURSTE)
            return WIN_BURST;
        else if (sub[8:2] == OFS_HOLD[8:2])
            return WIN_HOLD;
        else
            return WIN_REG;
    endfunction

    function automatic logic [1:0] ufp_last_step(input ufp_win_e kind);
        case (kind)
            WIN_BURST: return 2'h3;
            WIN_STAT:  return 2'h1;
            default:   return 2'h0;
        endcase
    endfunction

endpackage

/* logic/ufp_fifo_if.sv */
// Push/pop handshake bundle between the channel logic and one FIFO
`timescale 1ns/10ps
`default_nettype none
interface ufp_fifo_if
    import ufp_pkg::*;
#(
    parameter int W = 8
);
    logic               push_valid;
    logic               push_ready;
    logic [W-1:0]       push_data;
    logic               pop_valid;
    logic               pop_ready;
    logic [W-1:0]       pop_data;
    logic [LEVEL_W-1:0] level;

    modport fifo (input push_valid, input push_data, input pop_ready,
                  output push_ready, output pop_valid, output pop_data, output level);
    modport user (output push_valid, output push_data, output pop_ready,
                  input push_ready, input pop_valid, input pop_data, input level);
endinterface
`default_nettype wire

/* logic/ufp_fifo.sv */
// Parameterised FIFO with registered head word and registered flags
`timescale 1ns/10ps
`default_nettype none
module ufp_fifo
    import ufp_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    ufp_fifo_if.fifo  port_if
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] wptr_d;
    logic [AW-1:0] rptr_q;
    logic [AW-1:0] rptr_d;
    logic [AW:0]   count_q;
    logic [AW:0]   count_d;
    logic          room_q;
    logic          room_d;
    logic          avail_q;
    logic          avail_d;
    logic [W-1:0]  dout_q;
    logic [W-1:0]  dout_d;
    logic          do_push;
    logic          do_pop;

    always_comb begin
        // A push into a full FIFO is dropped; stored words stay intact
        do_push = port_if.push_valid & room_q;
        do_pop  = port_if.pop_ready & avail_q;
        wptr_d  = wptr_q + AW'(do_push);
        rptr_d  = rptr_q + AW'(do_pop);
        count_d = count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        room_d  = (count_d != (AW+1)'(DEPTH));
        avail_d = (count_d != '0);
        // Bypass so a word pushed into an empty FIFO is visible at once
        if (do_push && wptr_q == rptr_d) begin
            dout_d = port_if.push_data;
        end else begin
            dout_d = mem_q[rptr_d];
        end
    end

    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem_q[wptr_q] <= port_if.push_data;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
            room_q  <= 1'b1;
            avail_q <= 1'b0;
            dout_q  <= '0;
        end else begin
            wptr_q  <= wptr_d;
            rptr_q  <= rptr_d;
            count_q <= count_d;
            room_q  <= room_d;
            avail_q <= avail_d;
            dout_q  <= dout_d;
        end
    end

    // Flags kept in port polarity so ready and valid leave a flop directly
    assign port_if.push_ready = room_q;
    assign port_if.pop_valid  = avail_q;
    assign port_if.pop_data   = dout_q;
    assign port_if.level      = LEVEL_W'(count_q);
endmodule // ufp_fifo
`default_nettype wire

/* logic/ufp_top.sv */
// Eight-channel UART data port: FIFO windows, holding registers and baud generators
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module ufp_top
    import ufp_pkg::*;
(
    input  wire logic                      clk_in,
    input  wire logic                      resetn_in,
    input  wire logic                      bus_req_in,
    input  wire logic                      bus_we_in,
    input  wire logic [11:0]               bus_addr_in,
    input  wire logic [3:0]                bus_be_in,
    input  wire logic [31:0]               bus_wdata_in,
    output logic      [31:0]               bus_rdata_out,
    output logic                           bus_ack_out,
    input  wire logic [NCH-1:0]            rx_valid_in,
    input  wire logic [NCH-1:0][BYTE_W-1:0] rx_data_in,
    input  wire logic [NCH-1:0][BYTE_W-1:0] rx_status_in,
    output logic      [NCH-1:0]            rx_ready_out,
    output logic      [NCH-1:0]            tx_valid_out,
    output logic      [NCH-1:0][BYTE_W-1:0] tx_data_out,
    input  wire logic [NCH-1:0]            tx_ready_in,
    output logic      [NCH-1:0]            sample_tick_out,
    output logic      [NCH-1:0]            bit_tick_out
);

    //////////////////////////////////////////////////////////////////////////
    // Declarations

    ufp_state_e                state_q;
    ufp_state_e                state_d;
    ufp_win_e                  kind_q;
    ufp_win_e                  kind_d;
    ufp_win_e                  win;
    logic [2:0]                ch_q;
    logic [2:0]                ch_d;
    logic [3:0]                be_q;
    logic [3:0]                be_d;
    logic [31:0]               wdata_q;
    logic [31:0]               wdata_d;
    logic [1:0]                step_q;
    logic [1:0]                step_d;
    logic [1:0]                lane;
    logic [31:0]               rdata_q;
    logic [31:0]               rdata_d;
    logic                      ack_q;
    logic                      ack_d;
    logic                      take;
    logic [2:0]                bus_ch;
    logic [8:0]                bus_word;
    logic [31:0]               reg_rdata;
    logic [NCH-1:0]            pop_req;
    logic [NCH-1:0]            push_req;
    logic [BYTE_W-1:0]         push_byte;

    logic [NCH-1:0][7:0]       modem_q;
    logic [NCH-1:0][7:0]       modem_d;
    logic [NCH-1:0][7:0]       div_lo_q;
    logic [NCH-1:0][7:0]       div_lo_d;
    logic [NCH-1:0][7:0]       div_hi_q;
    logic [NCH-1:0][7:0]       div_hi_d;
    logic [7:0]                mode_q;
    logic [7:0]                mode_d;

    logic [NCH-1:0][RXF_W-1:0] rx_head;
    logic [NCH-1:0]            rx_nonempty;
    logic [NCH-1:0][LEVEL_W-1:0] rx_level;
    logic [NCH-1:0][LEVEL_W-1:0] tx_level;

    //////////////////////////////////////////////////////////////////////////
    // Address decode

    always_comb begin
        bus_ch   = bus_addr_in[11:9];
        bus_word = {bus_addr_in[8:2], 2'b00};
        win      = ufp_window(bus_addr_in[8:0]);
        // Ack is still high in the cycle after a transfer; do not retake that request
        take     = (state_q == ST_IDLE) && bus_req_in && !ack_q;
    end

    always_comb begin
        reg_rdata = 32'h0000_0000;
        case (bus_word)
            OFS_MODEM: reg_rdata = {24'h00_0000, modem_q[bus_ch]};
            OFS_LEVEL: reg_rdata = {16'h0000, 1'b0, tx_level[bus_ch], 1'b0, rx_level[bus_ch]};
            OFS_DIV:   reg_rdata = {16'h0000, div_hi_q[bus_ch], div_lo_q[bus_ch]};
            OFS_MODE:  reg_rdata = (bus_ch == 3'h0) ? {24'h00_0000, mode_q} : 32'h0000_0000;
            default:   reg_rdata = 32'h0000_0000;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_comb begin
        modem_d  = modem_q;
        div_lo_d = div_lo_q;
        div_hi_d = div_hi_q;
        mode_d   = mode_q;
        if (take && bus_we_in && win == WIN_REG) begin
            if (bus_word == OFS_MODEM && bus_be_in[0]) begin
                modem_d[bus_ch] = bus_wdata_in[7:0];
            end
            if (bus_word == OFS_DIV && bus_be_in[0]) begin
                div_lo_d[bus_ch] = bus_wdata_in[7:0];
            end
            if (bus_word == OFS_DIV && bus_be_in[1]) begin
                div_hi_d[bus_ch] = bus_wdata_in[15:8];
            end
            if (bus_word == OFS_MODE && bus_ch == 3'h0 && bus_be_in[0]) begin
                mode_d = bus_wdata_in[7:0];
            end
        end
    end

    // Divisor is cleared anyway so simulation starts from a known value
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            modem_q  <= {NCH{MODEM_RESET}};
            div_lo_q <= {NCH{DIV_RESET}};
            div_hi_q <= {NCH{DIV_RESET}};
            mode_q   <= MODE_RESET;
        end else begin
            modem_q  <= modem_d;
            div_lo_q <= div_lo_d;
            div_hi_q <= div_hi_d;
            mode_q   <= mode_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Access sequencer: one FIFO byte or pair per cycle

    always_comb begin
        state_d   = state_q;
        ch_d      = ch_q;
        kind_d    = kind_q;
        be_d      = be_q;
        wdata_d   = wdata_q;
        step_d    = step_q;
        rdata_d   = rdata_q;
        ack_d     = 1'b0;
        pop_req   = '0;
        push_req  = '0;
        push_byte = 8'h00;
        lane      = (kind_q == WIN_HOLD) ? 2'h0 : step_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    ch_d    = bus_ch;
                    kind_d  = win;
                    be_d    = bus_be_in;
                    wdata_d = bus_wdata_in;
                    step_d  = 2'h0;
                    rdata_d = 32'h0000_0000;
                    if (win == WIN_REG) begin
                        rdata_d = bus_we_in ? 32'h0000_0000 : reg_rdata;
                        state_d = ST_DONE;
                    end else if (bus_we_in) begin
                        // Status window is read-only; writes end at once
                        state_d = (win == WIN_STAT) ? ST_DONE : ST_WRITE;
                    end else begin
                        state_d = ST_READ;
                    end
                end
            end
            ST_READ: begin
                case (kind_q)
                    WIN_BURST: begin
                        if (be_q[step_q] && rx_nonempty[ch_q]) begin
                            rdata_d[{step_q, 3'b000} +: 8] = rx_head[ch_q][15:8];
                            pop_req[ch_q] = 1'b1;
                        end
                    end
                    WIN_STAT: begin
                        if ((be_q[{step_q[0], 1'b0}] || be_q[{step_q[0], 1'b1}]) && rx_nonempty[ch_q]) begin
                            rdata_d[{step_q[0], 4'h0} +: 16] = rx_head[ch_q];
                            pop_req[ch_q] = 1'b1;
                        end
                    end
                    default: begin
                        if (be_q[0] && rx_nonempty[ch_q]) begin
                            rdata_d[7:0]  = rx_head[ch_q][15:8];
                            pop_req[ch_q] = 1'b1;
                        end
                    end
                endcase
                if (step_q == ufp_last_step(kind_q)) begin
                    state_d = ST_DONE;
                end else begin
                    step_d = step_q + 2'h1;
                end
            end
            ST_WRITE: begin
                // Lanes go in one per cycle, lane 0 first
                if (be_q[lane]) begin
                    push_req[ch_q] = 1'b1;
                    push_byte      = wdata_q[{lane, 3'b000} +: 8];
                end
                if (step_q == ufp_last_step(kind_q)) begin
                    state_d = ST_DONE;
                end else begin
                    step_d = step_q + 2'h1;
                end
            end
            ST_DONE: begin
                ack_d   = 1'b1;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= ST_IDLE;
            ch_q    <= 3'h0;
            kind_q  <= WIN_HOLD;
            be_q    <= 4'h0;
            wdata_q <= 32'h0000_0000;
            step_q  <= 2'h0;
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            ch_q    <= ch_d;
            kind_q  <= kind_d;
            be_q    <= be_d;
            wdata_q <= wdata_d;
            step_q  <= step_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
        end
    end

    assign bus_rdata_out = rdata_q;
    assign bus_ack_out   = ack_q;

    //////////////////////////////////////////////////////////////////////////
    // Per-channel FIFOs and baud generation

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        ufp_fifo_if #(.W(RXF_W))  rx_if ();
        ufp_fifo_if #(.W(BYTE_W)) tx_if ();

        // Rx entries pack status low, data high to match the paired window
        ufp_fifo #(.W(RXF_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .port_if   (rx_if.fifo)
        );

        ufp_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
            .clk_in    (clk_in),
            .resetn_in (resetn_in),
            .port_if   (tx_if.fifo)
        );

        assign rx_if.push_valid = rx_valid_in[c];
        assign rx_if.push_data  = {rx_data_in[c], rx_status_in[c]};
        assign rx_if.pop_ready  = pop_req[c];
        assign rx_ready_out[c]  = rx_if.push_ready;
        assign rx_head[c]       = rx_if.pop_data;
        assign rx_nonempty[c]   = rx_if.pop_valid;
        assign rx_level[c]      = rx_if.level;

        assign tx_if.push_valid = push_req[c];
        assign tx_if.push_data  = push_byte;
        assign tx_if.pop_ready  = tx_ready_in[c];
        assign tx_valid_out[c]  = tx_if.pop_valid;
        assign tx_data_out[c]   = tx_if.pop_data;
        assign tx_level[c]      = tx_if.level;

        logic [1:0]  pre_q;
        logic [1:0]  pre_d;
        logic [15:0] cnt_q;
        logic [15:0] cnt_d;
        logic [3:0]  bcnt_q;
        logic [3:0]  bcnt_d;
        logic        samp_q;
        logic        samp_d;
        logic        bit_q;
        logic        bit_d;
        logic        pre_tick;
        logic [15:0] divisor;
        logic [3:0]  bit_last;

        always_comb begin
            pre_tick = modem_q[c][PRESCALE_BIT] ? (pre_q == PRESCALE_LAST) : 1'b1;
            pre_d    = pre_tick ? 2'h0 : pre_q + 2'h1;
            divisor  = {div_hi_q[c], div_lo_q[c]};
            bit_last = mode_q[c] ? BIT_LAST_8X : BIT_LAST_16X;
            cnt_d    = cnt_q;
            samp_d   = 1'b0;
            bcnt_d   = bcnt_q;
            bit_d    = 1'b0;
            if (pre_tick) begin
                // A zero divisor wraps to the longest period rather than stalling
                if (cnt_q >= divisor - 16'h0001) begin
                    cnt_d  = 16'h0000;
                    samp_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            if (samp_d) begin
                if (bcnt_q >= bit_last) begin
                    bcnt_d = 4'h0;
                    bit_d  = 1'b1;
                end else begin
                    bcnt_d = bcnt_q + 4'h1;
                end
            end
        end

        always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                pre_q  <= 2'h0;
                cnt_q  <= 16'h0000;
                bcnt_q <= 4'h0;
                samp_q <= 1'b0;
                bit_q  <= 1'b0;
            end else begin
                pre_q  <= pre_d;
                cnt_q  <= cnt_d;
                bcnt_q <= bcnt_d;
                samp_q <= samp_d;
                bit_q  <= bit_d;
            end
        end

        assign sample_tick_out[c] = samp_q;
        assign bit_tick_out[c]    = bit_q;
    end

endmodule // ufp_top
`default_nettype wire

/* bench/ufp_top_props.sv */
// Port-level assertions for the octal UART data port
`timescale 1ns/10ps
`default_nettype none
module ufp_top_props
    import ufp_pkg::*;
(
    input wire logic                        clk_in,
    input wire logic                        resetn_in,
    input wire logic                        bus_req_in,
    input wire logic                        bus_we_in,
    input wire logic [11:0]                 bus_addr_in,
    input wire logic [3:0]                  bus_be_in,
    input wire logic [31:0]                 bus_wdata_in,
    input wire logic [31:0]                 bus_rdata_out,
    input wire logic                        bus_ack_out,
    input wire logic [NCH-1:0]              rx_valid_in,
    input wire logic [NCH-1:0][BYTE_W-1:0]  rx_data_in,
    input wire logic [NCH-1:0][BYTE_W-1:0]  rx_status_in,
    input wire logic [NCH-1:0]              rx_ready_out,
    input wire logic [NCH-1:0]              tx_valid_out,
    input wire logic [NCH-1:0][BYTE_W-1:0]  tx_data_out,
    input wire logic [NCH-1:0]              tx_ready_in,
    input wire logic [NCH-1:0]              sample_tick_out,
    input wire logic [NCH-1:0]              bit_tick_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    //////////////////////////////////////////////////////////////////////////////
    property p_ack_bound; $rose(bus_req_in) |-> ##[1:7] bus_ack_out; endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("access not answered");
    property p_ack_req; bus_ack_out |-> $past(bus_req_in); endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    property p_tick_pair; (bit_tick_out & ~sample_tick_out) == '0; endproperty
    a_tick_pair: assert property (p_tick_pair) else $error("bit tick off sample tick");
    property p_bit_gap; bit_tick_out != '0 |=> (bit_tick_out & $past(bit_tick_out)) == '0; endproperty
    a_bit_gap: assert property (p_bit_gap) else $error("bit ticks too close");
    property p_tx_hold; tx_valid_out[0] && !tx_ready_in[0] |=> tx_valid_out[0] && $stable(tx_data_out[0]); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx head moved without pop");
    property p_rx_rise; (rx_ready_out & ~$past(rx_ready_out)) != '0 |-> $past(bus_req_in); endproperty
    a_rx_rise: assert property (p_rx_rise) else $error("rx space without host read");
    property p_tx_rise; (tx_valid_out & ~$past(tx_valid_out)) != '0 |-> $past(bus_req_in && bus_we_in); endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("tx data without host write");
    property p_rx_fall; (~rx_ready_out & $past(rx_ready_out & ~rx_valid_in)) == '0; endproperty
    a_rx_fall: assert property (p_rx_fall) else $error("rx full without push");
    c_full: cover property (rx_ready_out != '1);
    c_bit: cover property (bit_tick_out != '0);
    c_pop: cover property (tx_valid_out[0] && tx_ready_in[0]);
endmodule // ufp_top_props
bind ufp_top ufp_top_props u_props (.*);
`default_nettype wire

/* bench/ufp_host_model.sv */
// Host bus master model issuing one access at a time
`timescale 1ns/10ps
`default_nettype none
module ufp_host_model (
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic [31:0] rdata_in,
    output logic             req_out,
    output logic             we_out,
    output logic [11:0]      addr_out,
    output logic [3:0]       be_out,
    output logic [31:0]      wdata_out
);
    int to_cnt = 0;
    initial begin
        req_out = 1'b0;
        we_out = 1'b0;
        addr_out = 12'h000;
        be_out = 4'h0;
        wdata_out = 32'h0;
    end
    // Width follows the window: bytes to holding, words to paired window
    task automatic access(input logic w, input logic [11:0] a, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(negedge clk_in);
        req_out = 1'b1;
        we_out = w;
        addr_out = a;
        be_out = be;
        wdata_out = wd;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (ack_in !== 1'b1 && n < 20);
        if (ack_in !== 1'b1) to_cnt++;
        // Hold the request through the edge that samples ack
        @(negedge clk_in);
        rd = rdata_in;
        req_out = 1'b0;
        // Released address and data lines flip so stale values never look valid
        addr_out = ~a;
        wdata_out = ~wd;
    endtask
endmodule // ufp_host_model
`default_nettype wire

/* bench/ufp_top_bench.sv */
// Self-checking bench for the octal UART data port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
    ev = 32'(e); \
    n_tests++; \
    if (32'(a) !== ev) begin \
        error_cnt++; \
        $display("mismatch at %0t: got %h want %h", $time, a, ev); \
    end \
end
module ufp_top_bench;
    import ufp_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic bus_req_in, bus_we_in, bus_ack_out;
    logic [11:0] bus_addr_in;
    logic [3:0] bus_be_in;
    logic [31:0] bus_wdata_in, bus_rdata_out, r, ev;
    logic [NCH-1:0] rx_valid_in = '0, tx_ready_in = '0, rx_ready_out, tx_valid_out, sample_tick_out, bit_tick_out;
    logic [NCH-1:0][BYTE_W-1:0] rx_data_in = '0, rx_status_in = '0, tx_data_out;
    logic [7:0] dq[$], sq[$], tq[$];
    int error_cnt = 0, n_tests = 0, seed = 32'h01d9, c, g;
    ufp_top u_dut (.*);
    ufp_host_model u_host (.clk_in(clk_in), .ack_in(bus_ack_out), .rdata_in(bus_rdata_out),
        .req_out(bus_req_in), .we_out(bus_we_in), .addr_out(bus_addr_in), .be_out(bus_be_in),
        .wdata_out(bus_wdata_in));
    always #5 clk_in = ~clk_in;
    //////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        error_cnt += u_host.to_cnt;
        if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [8:0] o, input logic [3:0] be, input logic [31:0] d);
        u_host.access(w, {c[2:0], o}, be, d, r);
        if (u_host.to_cnt != 0) wrap_up();
    endtask
    // Oldest byte in lowest lane; paired form puts status under data
    function automatic logic [31:0] exp_rx(input bit pair, input int n);
        logic [31:0] v;
        v = '0;
        for (int i = 0; i < n; i++) begin
            if (dq.size() != 0 && pair) v[16*i+:16] = {dq.pop_front(), sq.pop_front()};
            else if (dq.size() != 0) v[8*i+:8] = dq.pop_front();
            if (!pair && sq.size() > dq.size()) void'(sq.pop_front());
        end
        return v;
    endfunction
    task automatic rx_push(input int n);
        repeat (n) begin
            @(negedge clk_in);
            rx_valid_in[c] = 1'b1;
            rx_data_in[c] = 8'($random(seed));
            rx_status_in[c] = 8'($random(seed));
            if (rx_ready_out[c] === 1'b1) dq.push_back(rx_data_in[c]);
            if (rx_ready_out[c] === 1'b1) sq.push_back(rx_status_in[c]);
        end
        @(negedge clk_in);
        rx_valid_in[c] = 1'b0;
        rx_data_in[c] = ~rx_data_in[c];
    endtask
    task automatic tx_pop();
        int n = 0;
        while (tx_valid_out[c] !== 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 50) error_cnt++;
        if (n == 50) wrap_up();
        `CHK(tx_data_out[c], tq.pop_front())
        tx_ready_in[c] = 1'b1;
        @(negedge clk_in);
        tx_ready_in[c] = 1'b0;
        repeat ($random(seed) & 3) @(negedge clk_in);
    endtask
    // Gap between two ticks after settling on the new setting
    task automatic gap(input int ch, input bit b);
        repeat (3) begin
            g = 0;
            do begin
                @(negedge clk_in);
                g++;
            end while ((b ? bit_tick_out[ch] : sample_tick_out[ch]) !== 1'b1 && g < 20000);
            if (g == 20000) error_cnt++;
            if (g == 20000) wrap_up();
        end
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge clk_in);
        resetn_in = 1'b1;
        `CHK(rx_ready_out, {NCH{1'b1}})
        `CHK(tx_valid_out, {NCH{1'b0}})
        c = $random(seed) & 7;
        rx_push(6);
        acc(0, 9'h100, 4'hf, 0);
        `CHK(r, exp_rx(0, 4))
        acc(0, 9'h180, 4'hf, 0);
        `CHK(r, exp_rx(1, 2))
        acc(0, 9'h100, 4'hf, 0);
        `CHK(r, 32'h0)
        rx_push(2);
        repeat (2) begin
            acc(0, 9'h000, 4'h1, 0);
            `CHK(r[7:0], exp_rx(0, 1))
        end
        rx_push(70);
        `CHK(dq.size(), 64)
        `CHK(rx_ready_out[c], 1'b0)
        acc(0, 9'h00c, 4'hf, 0);
        `CHK(r, 32'h0000_0040)
        repeat (17) begin
            acc(0, 9'h100, 4'hf, 0);
            `CHK(r, exp_rx(0, 4))
        end
        `CHK(rx_ready_out[c], 1'b1)
        c = 0;
        g = $random(seed);
        acc(1, 9'h000, 4'h1, g);
        tq.push_back(g[7:0]);
        for (int k = 0; k < 17; k++) begin
            g = $random(seed);
            acc(1, 9'h100, k ? 4'hf : 4'ha, g);
            for (int i = 0; i < 4; i++) if ((k || i[0]) && tq.size() < 64) tq.push_back(g[8*i+:8]);
        end
        repeat (64) tx_pop();
        repeat (2) @(negedge clk_in);
        `CHK(tx_valid_out[c], 1'b0)
        c = 2;
        acc(1, 9'h004, 4'h1, 32'h80);
        acc(1, 9'h010, 4'h3, 32'h0003);
        c = 0;
        acc(1, 9'h088, 4'h1, 32'h04);
        gap(2, 0);
        `CHK(g, 12)
        gap(2, 1);
        `CHK(g, 96)
        c = 5;
        acc(1, 9'h010, 4'h3, 32'h0105);
        gap(5, 0);
        `CHK(g, 261)
        gap(5, 1);
        `CHK(g, 4176)
        acc(0, 9'h010, 4'h3, 0);
        `CHK(r, 32'h0000_0105)
        wrap_up();
    end
endmodule // ufp_top_bench
`default_nettype wire
